/* rtl/kclk_pkg.sv */
// Constants for the kernel clock divider block: register map, field layout and divide tables.
package kclk_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam int ADDR_W = 8;
    localparam logic [7:0] KDIV_OFFSET = 8'h2c;
    localparam logic [7:0] STATUS_OFFSET = 8'h40;
    localparam logic [31:0] KDIV_RESET = 32'h0000_7000;
    // Writable bits; reserved bits 31:30, 23:18 and 11:9 always read zero.
    localparam logic [31:0] KDIV_WMASK = 32'h3f03_f1ff;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of the divide register.
    localparam int TSEL_BIT = 29;
    localparam int RNG_MSB = 28;
    localparam int RNG_LSB = 24;
    localparam int REFSEL_BIT = 17;
    localparam int REF_MSB = 16;
    localparam int REF_LSB = 12;
    localparam int PLL_EN_BIT = 8;
    localparam int PLL_MSB = 7;
    localparam int PLL_LSB = 4;
    localparam int AHB_MSB = 3;
    localparam int AHB_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Status register bit positions.
    localparam int ST_TIMER_SYS = 0;
    localparam int ST_TIMER_DOUBLE = 1;
    localparam int ST_REF_EXT = 2;
    localparam int ST_PLL_ACTIVE = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Divide factors.
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] DIV_ONE = 9'h001;
    localparam logic [3:0] PLL_LAST_CODE = 4'hb;
    localparam logic [3:0] AHB_LAST_CODE = 4'h8;
    localparam logic [DIV_W-1:0] PLL_DIV_TABLE [12] = '{
        9'h001, 9'h002, 9'h004, 9'h006, 9'h008, 9'h00a,
        9'h00c, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100
    };
    localparam logic [DIV_W-1:0] AHB_DIV_TABLE [9] = '{
        9'h001, 9'h002, 9'h004, 9'h006, 9'h008, 9'h00a, 9'h00c, 9'h010, 9'h020
    };

endpackage

/* rtl/tick_divider.sv */
// Enable-pulse divider that changes its factor only at the end of a divided period.
`timescale 1ns/100ps
module tick_divider #(
    parameter int W = 9
) (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic src_tick, // one-cycle pulse of the source rate
    input wire logic enable, // divider may run
    input wire logic [W-1:0] divisor, // divide factor, 1 or more
    output logic div_tick, // one-cycle pulse of the divided rate
    output logic active // divider is running
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] div_l;
        logic en_l;
        logic tick;
    } div_state_t;

    div_state_t st_r;
    div_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Factor and enable are sampled only at a period boundary, so a change never
    // cuts a period short and the output never carries a runt pulse.
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!st_r.en_l) begin
            if (enable) begin
                st_nxt.en_l = 1'b1;
                st_nxt.div_l = (divisor == '0) ? W'(1) : divisor;
                st_nxt.cnt = '0;
            end
        end else if (src_tick) begin
            if (st_r.cnt >= st_r.div_l - W'(1)) begin
                st_nxt.tick = 1'b1;
                st_nxt.cnt = '0;
                st_nxt.div_l = (divisor == '0) ? W'(1) : divisor;
                st_nxt.en_l = enable;
            end else begin
                st_nxt.cnt = st_r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{cnt: '0, div_l: W'(1), en_l: 1'b0, tick: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign div_tick = st_r.tick;
    assign active = st_r.en_l;

endmodule // tick_divider

/* rtl/kernel_clock_divide.sv */
// Kernel clock selection and division for the advanced timers, random-number core and ADC.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module kernel_clock_divide
    import kclk_pkg::*;
(
    input wire logic sys_clk, // system clock, 10 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [kclk_pkg::ADDR_W-1:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [31:0] reg_rdata, // read data, valid the cycle after the read strobe
    input wire logic apb_prescale_one, // fast peripheral bus prescaler is one
    input wire logic periph_tick, // fast peripheral clock enable pulse
    input wire logic periph_double_tick, // twice-rate fast peripheral clock enable pulse
    input wire logic int_osc_tick, // internal fast oscillator enable pulse
    input wire logic ext_osc_tick, // external fast oscillator enable pulse
    input wire logic pll_tick, // PLL clock enable pulse
    input wire logic ahb_tick, // AHB clock enable pulse
    output logic adv_timer_tick, // advanced timers clock enable pulse
    output logic rng_core_tick, // random-number core clock enable pulse
    output logic adc_ref_tick, // ADC reference clock enable pulse
    output logic adc_pll_tick, // PLL-derived ADC clock enable pulse
    output logic adc_ahb_tick // AHB-derived ADC clock enable pulse
);
    import kclk_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Divide-factor lookups.

    function automatic logic [DIV_W-1:0] pll_factor(input logic [3:0] code);
        logic [DIV_W-1:0] f;
        f = PLL_DIV_TABLE[PLL_LAST_CODE];
        if (code <= PLL_LAST_CODE) begin
            f = PLL_DIV_TABLE[code];
        end
        return f;
    endfunction

    function automatic logic [DIV_W-1:0] ahb_factor(input logic [3:0] code);
        logic [DIV_W-1:0] f;
        f = AHB_DIV_TABLE[AHB_LAST_CODE];
        if (code <= AHB_LAST_CODE) begin
            f = AHB_DIV_TABLE[code];
        end
        return f;
    endfunction

    function automatic logic [DIV_W-1:0] plus_one(input logic [4:0] code);
        return DIV_W'(code) + DIV_ONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [31:0] kdiv;
        logic [31:0] rdata;
        logic tsel;
        logic tpres_one;
        logic refsel;
        logic timer_tick;
        logic ref_started;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    logic rng_div_tick;
    logic ref_div_tick;
    logic pll_div_tick;
    logic pll_active;
    logic ahb_div_tick;
    logic ref_src_tick;
    logic timer_src_tick;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Source selections in use. The select bits are only taken over at an edge of
    // the source now in use, so the old clock finishes its period before the new
    // one starts; the cost is a switch latency of up to one slow source period for the timer and one divided period for the reference.

    always_comb begin
        if (st_r.tsel) begin
            timer_src_tick = 1'b1;
        end else if (st_r.tpres_one) begin
            timer_src_tick = periph_tick;
        end else begin
            timer_src_tick = periph_double_tick;
        end
    end

    assign ref_src_tick = st_r.refsel ? ext_osc_tick : int_osc_tick;

    always_comb begin
        status_word = READ_ZERO;
        status_word[ST_TIMER_SYS] = st_r.tsel;
        status_word[ST_TIMER_DOUBLE] = ~st_r.tsel & ~st_r.tpres_one;
        status_word[ST_REF_EXT] = st_r.refsel;
        status_word[ST_PLL_ACTIVE] = pll_active;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register access and selection hand-over.

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = READ_ZERO;
        if (reg_wr) begin
            if (reg_addr == KDIV_OFFSET) begin
                st_nxt.kdiv = reg_wdata & KDIV_WMASK;
            end
        end
        if (reg_rd) begin
            if (reg_addr == KDIV_OFFSET) begin
                st_nxt.rdata = st_r.kdiv;
            end else if (reg_addr == STATUS_OFFSET) begin
                st_nxt.rdata = status_word;
            end else begin
                st_nxt.rdata = READ_ZERO;
            end
        end
        // Timer source changes only on an edge of the source in use.
        st_nxt.timer_tick = timer_src_tick;
        if (timer_src_tick) begin
            st_nxt.tsel = st_r.kdiv[TSEL_BIT];
            st_nxt.tpres_one = apb_prescale_one;
        end
        // Reference source changes only at the end of a divided period.
        if (ref_div_tick || !st_r.ref_started) begin
            st_nxt.refsel = st_r.kdiv[REFSEL_BIT];
            st_nxt.ref_started = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{kdiv: KDIV_RESET, rdata: READ_ZERO, tsel: 1'b0,
                      tpres_one: 1'b0, refsel: 1'b0, timer_tick: 1'b0,
                      ref_started: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dividers.

    tick_divider #(.W(DIV_W)) u_rng_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_tick(1'b1),
        .enable(1'b1),
        .divisor(plus_one(st_r.kdiv[RNG_MSB:RNG_LSB])),
        .div_tick(rng_div_tick),
        .active()
    );

    tick_divider #(.W(DIV_W)) u_ref_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_tick(ref_src_tick),
        .enable(1'b1),
        .divisor(plus_one(st_r.kdiv[REF_MSB:REF_LSB])),
        .div_tick(ref_div_tick),
        .active()
    );

    tick_divider #(.W(DIV_W)) u_pll_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_tick(pll_tick),
        .enable(st_r.kdiv[PLL_EN_BIT]),
        .divisor(pll_factor(st_r.kdiv[PLL_MSB:PLL_LSB])),
        .div_tick(pll_div_tick),
        .active(pll_active)
    );

    tick_divider #(.W(DIV_W)) u_ahb_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_tick(ahb_tick),
        .enable(1'b1),
        .divisor(ahb_factor(st_r.kdiv[AHB_MSB:AHB_LSB])),
        .div_tick(ahb_div_tick),
        .active()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata = st_r.rdata;
    assign adv_timer_tick = st_r.timer_tick;
    assign rng_core_tick = rng_div_tick;
    assign adc_ref_tick = ref_div_tick;
    assign adc_pll_tick = pll_div_tick;
    assign adc_ahb_tick = ahb_div_tick;

endmodule // kernel_clock_divide

/* bench/kclk_assertions.sv */
// Port-level checks for the kernel clock divider.
`timescale 1ns/100ps
module kclk_checker (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [31:0] reg_rdata, // read data
    input wire logic int_osc_tick, // osc
    input wire logic ext_osc_tick, // osc
    input wire logic pll_tick, // pll
    input wire logic ahb_tick, // ahb
    input wire logic adv_timer_tick, // timer out
    input wire logic rng_core_tick, // rng out
    input wire logic adc_ref_tick, // ref out
    input wire logic adc_pll_tick, // pll out
    input wire logic adc_ahb_tick // ahb out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] shadow_r;
    logic [1:0] late_r;
    // A disabled PLL path may finish its current period, so one late pulse is allowed.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_r <= 32'h0000_7000;
            late_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h2c) shadow_r <= reg_wdata & 32'h3f03_f1ff;
            if (shadow_r[8]) late_r <= 2'h0;
            else if (adc_pll_tick && late_r != 2'h3) late_r <= late_r + 2'h1;
        end
    end
    a_read_back: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h2c |-> reg_rdata == $past(shadow_r))
        else $error("readback");
    a_unmapped_zero: assert property (
        $past(reg_rd) && !($past(reg_addr) inside {8'h2c, 8'h40}) |-> reg_rdata == 32'h0)
        else $error("unmapped");
    a_timer_sys: assert property (
        shadow_r[29] && $past(shadow_r[29], 3) && $past(adv_timer_tick) |-> adv_timer_tick)
        else $error("timer");
    a_pll_off: assert property (!shadow_r[8] |-> late_r <= 2'h1)
        else $error("pll off");
    a_rng_half: assert property (
        $rose(rng_core_tick) && shadow_r[28:24] == 5'h1 && $past(shadow_r[28:24]) == 5'h1
        |-> ##1 !rng_core_tick ##1 rng_core_tick) else $error("rng");
    a_ahb_src: assert property (adc_ahb_tick |-> $past(ahb_tick))
        else $error("ahb");
    a_pll_src: assert property (adc_pll_tick |-> $past(pll_tick))
        else $error("pll");
    a_ref_src: assert property (adc_ref_tick |-> $past(int_osc_tick || ext_osc_tick))
        else $error("ref");
    cover property (adc_pll_tick && shadow_r[8]);
    cover property (!shadow_r[8] && adc_pll_tick);
    cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule // kclk_checker
bind kernel_clock_divide kclk_checker kclk_checker_i (.*);

/* bench/testbench.sv */
// Self-checking bench for the kernel clock divider.
`timescale 1ns/100ps
module testbench;
    import kclk_pkg::*;
    logic sys_clk, rst_n, reg_wr, reg_rd, apb_prescale_one;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, kreg, d;
    logic periph_tick, periph_double_tick, int_osc_tick, ext_osc_tick, pll_tick, ahb_tick;
    logic adv_timer_tick, rng_core_tick, adc_ref_tick, adc_pll_tick, adc_ahb_tick;
    int n_errors, comparisons;
    int pll_f[16] = '{1, 2, 4, 6, 8, 10, 12, 16, 32, 64, 128, 256, 256, 256, 256, 256};
    int ahb_f[16] = '{1, 2, 4, 6, 8, 10, 12, 16, 32, 32, 32, 32, 32, 32, 32, 32};
    kernel_clock_divide kernel_clock_divide_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        {periph_tick, periph_double_tick, int_osc_tick, ext_osc_tick, pll_tick, ahb_tick} <=
            6'($urandom);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
        @(posedge sys_clk);
    endtask
    // Counts source ticks between output pulses; the first gaps are skipped because
    // a new factor is only loaded at the end of a period.
    task automatic period(input int sel, input int exp);
        int cnt, k, g;
        logic o, s;
        cnt = 0;
        k = 0;
        for (g = 0; g < 9000 && k < 5; g++) begin
            @(negedge sys_clk);
            o = (sel == 0) ? rng_core_tick : (sel == 1) ? adc_ref_tick :
                (sel == 2) ? adc_pll_tick : adc_ahb_tick;
            s = (sel == 0) ? 1'b1 : (sel == 1) ? (kreg[17] ? ext_osc_tick : int_osc_tick) :
                (sel == 2) ? pll_tick : ahb_tick;
            if (o) begin
                if (k >= 3) check(32'(cnt), 32'(exp));
                k++;
                cnt = 0;
            end
            cnt += int'(s);
        end
        if (k < 5) begin
            n_errors++;
            results();
        end
        @(posedge sys_clk);
    endtask
    task automatic timer(input logic sel, input logic one);
        logic e;
        kreg[29] = sel;
        apb_prescale_one <= one;
        wr(8'h2c, kreg);
        repeat (30) @(posedge sys_clk);
        @(negedge sys_clk);
        repeat (40) begin
            e = sel ? 1'b1 : (one ? periph_tick : periph_double_tick);
            @(negedge sys_clk);
            check(32'(adv_timer_tick), 32'(e));
        end
        @(posedge sys_clk);
        // Status word: system-clock select, double peripheral rate, reference source, PLL path.
        rd(8'h40, d);
        check(d, 32'({1'b0, kreg[17], ~sel & ~one, sel}));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int c;
        logic [4:0] f;
        {rst_n, reg_wr, reg_rd, apb_prescale_one, reg_addr, reg_wdata} = '0;
        {periph_tick, periph_double_tick, int_osc_tick, ext_osc_tick, pll_tick, ahb_tick} = '0;
        n_errors = 0;
        comparisons = 0;
        void'($urandom(32'h5de0));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'h2c, d);
        check(d, 32'h0000_7000);
        kreg = 32'h0000_7000;
        period(1, 8);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, d);
        check(d, 32'h0);
        wr(8'h2c, 32'hffff_ffff);
        rd(8'h2c, d);
        check(d, 32'h3f03_f1ff);
        $display("register test done");
        for (c = 0; c < 16; c++) begin
            f = (c < 8) ? 5'(c) : 5'(2 * c + 1);
            kreg = {3'h0, f, 6'h0, 1'(c), 5'h1f - f, 3'h0, 1'b1, 4'(c), 4'(c)};
            wr(8'h2c, kreg | ($urandom & 32'hc0fc_0e00));
            rd(8'h2c, d);
            check(d, kreg);
            period(0, f + 1);
            period(1, 32 - f);
            period(2, pll_f[c]);
            period(3, ahb_f[c]);
            $display("divider code %0d done", c);
        end
        kreg[8] = 1'b0;
        wr(8'h2c, kreg);
        repeat (1500) @(posedge sys_clk);
        c = 0;
        repeat (600) begin
            @(negedge sys_clk);
            c += int'(adc_pll_tick);
        end
        check(32'(c), 32'h0);
        @(posedge sys_clk);
        $display("pll disable test done");
        timer(1'b1, 1'b0);
        timer(1'b0, 1'b1);
        timer(1'b0, 1'b0);
        $display("timer test done");
        results();
    end
endmodule // testbench
